// ==== design/wssb_regs.svh ====
// Register map, field positions, reset values and timing counts of the wake and switch status bank.
// Assumes inclusion by the package and the self-checking bench only.
`ifndef WSSB_REGS_SVH
`define WSSB_REGS_SVH

// ----------------------------------------
// Addresses on the 7-bit serial register space
// ----------------------------------------
`define WSSB_ADDR_W 7
`define WSSB_ADDR_WK_A 7'h46
`define WSSB_ADDR_WK_B 7'h47
`define WSSB_ADDR_LVL 7'h48
`define WSSB_ADDR_OVL 7'h54
`define WSSB_ADDR_OPL 7'h55

// ----------------------------------------
// Implemented bits of each register
// ----------------------------------------
`define WSSB_MASK_WK_A 8'h77
`define WSSB_MASK_WK_B 8'h30
`define WSSB_MASK_LVL 8'hf7
`define WSSB_MASK_HS 8'h0f
`define WSSB_RESET_FLAGS 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WSSB_BIT_LIN 6
`define WSSB_BIT_CAN 5
`define WSSB_BIT_TIMER 4
`define WSSB_BIT_WK1 0
`define WSSB_BIT_GP1 4
`define WSSB_BIT_DEV 7
`define WSSB_BIT_PULLUP 6
`define WSSB_BIT_GP_LVL 4
`define WSSB_BIT_WK_LVL 0

// ----------------------------------------
// Strap settling: cycles after reset release before the straps are taken
// ----------------------------------------
// The synchroniser output is valid only after its fourth edge, so capture waits one edge beyond that
`define WSSB_STRAP_SETTLE 3'h4

`endif

// ==== design/wssb_pkg.sv ====
// Types shared by the wake and switch status bank modules.
// Assumes the register header is on the include path.
package wssb_pkg;
`include "wssb_regs.svh"

    typedef logic [7:0] wssb_byte_t;

    // Strap capture state
    typedef enum logic [0:0] {
        WSSB_ST_SETTLE = 1'b0,
        WSSB_ST_LIVE = 1'b1
    } wssb_strap_st_t;

    // Source that ended fail-safe mode by a wake
    typedef enum logic [2:0] {
        WSSB_SRC_WK1 = 3'h0,
        WSSB_SRC_WK2 = 3'h1,
        WSSB_SRC_WK3 = 3'h2,
        WSSB_SRC_TIMER = 3'h3,
        WSSB_SRC_CAN = 3'h4,
        WSSB_SRC_LIN = 3'h5,
        WSSB_SRC_GP1 = 3'h6,
        WSSB_SRC_GP2 = 3'h7
    } wssb_src_t;
endpackage

// ==== design/wssb_sync.sv ====
// Three-stage synchroniser for pin levels entering the ref_clk domain.
// Assumes inputs may change at any time; the output moves once stages two and three agree.
`timescale 1ns/100ps
module wssb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } wssb_sync_st_t;

    wssb_sync_st_t s;
    wssb_sync_st_t next_s;

    // ----------------------------------------
    // Stages
    // ----------------------------------------
    // The first stage feeds only the second, so metastability never reaches a compare
    always_comb begin
        next_s = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.q);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;
endmodule // wssb_sync

// ==== design/wssb_bank.sv ====
// Wake source, input level and high-side fault status registers, read over the internal register port.
// Assumes the serial framing sits outside and gives one-cycle read strobes on ref_clk;
// event inputs come from same-clock logic, pin and strap levels from outside the domain.
`timescale 1ns/100ps
module wssb_bank
    import wssb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic soft_reset,
    // Register port
    input wire logic rd_strobe,
    input wire logic [`WSSB_ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Wake events, one-cycle pulses
    input wire logic lin_bus_wake,
    input wire logic can_bus_wake,
    input wire logic timer_wake,
    input wire logic [2:0] wake_input_wake,
    input wire logic [1:0] gp_pin_wake,
    input wire logic failsafe_wake_exit,
    input wire wssb_src_t failsafe_wake_src,
    // Switch fault events, one-cycle pulses
    input wire logic [3:0] switch_overload_event,
    input wire logic [3:0] switch_open_load_event,
    // Pins and straps
    input wire logic fail_output_test_pin,
    input wire logic int_pullup_pin,
    input wire logic [1:0] gp_pin,
    input wire logic [2:0] wake_input_pin,
    // Pin configuration
    input wire logic mode_normal_stop,
    input wire logic [1:0] gp_cfg_wake_or_switch,
    input wire logic [1:0] gp_selected,
    input wire logic [2:0] wake_cyclic,
    input wire logic [2:0] wake_sample
);
    typedef struct packed {
        wssb_byte_t wk_a;
        wssb_byte_t wk_b;
        wssb_byte_t ovl;
        wssb_byte_t opl;
        logic dev_mode_strap;
        logic int_pullup_strap;
        logic [1:0] gp_lvl;
        logic [2:0] wk_lvl;
        wssb_strap_st_t st;
        logic [2:0] settle;
        wssb_byte_t rd_data;
        logic rd_valid;
    } wssb_bank_st_t;

    wssb_bank_st_t s;
    wssb_bank_st_t next_s;
    logic [6:0] pin_sync;
    logic clr_a;
    logic clr_b;
    logic clr_ovl;
    logic clr_opl;
    wssb_byte_t ev_a;
    wssb_byte_t ev_b;
    logic [1:0] gp_refresh;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [`WSSB_ADDR_W-1:0] a, input logic [`WSSB_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // One-hot flag bits for a fail-safe wake source in either wake register
    function automatic wssb_byte_t src_bits(input wssb_src_t src, input logic reg_b);
        wssb_byte_t v;
        v = '0;
        case (src)
            WSSB_SRC_WK1: v[`WSSB_BIT_WK1] = !reg_b;
            WSSB_SRC_WK2: v[`WSSB_BIT_WK1 + 1] = !reg_b;
            WSSB_SRC_WK3: v[`WSSB_BIT_WK1 + 2] = !reg_b;
            WSSB_SRC_TIMER: v[`WSSB_BIT_TIMER] = !reg_b;
            WSSB_SRC_CAN: v[`WSSB_BIT_CAN] = !reg_b;
            WSSB_SRC_LIN: v[`WSSB_BIT_LIN] = !reg_b;
            WSSB_SRC_GP1: v[`WSSB_BIT_GP1] = reg_b;
            WSSB_SRC_GP2: v[`WSSB_BIT_GP1 + 1] = reg_b;
            default: v = '0;
        endcase
        src_bits = v;
    endfunction

    function automatic wssb_byte_t level_byte(input wssb_bank_st_t t);
        wssb_byte_t v;
        v = '0;
        v[`WSSB_BIT_DEV] = t.dev_mode_strap;
        v[`WSSB_BIT_PULLUP] = t.int_pullup_strap;
        v[`WSSB_BIT_GP_LVL +: 2] = t.gp_lvl;
        v[`WSSB_BIT_WK_LVL +: 3] = t.wk_lvl;
        level_byte = v & `WSSB_MASK_LVL;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wssb_sync #(
        .W(7)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d({fail_output_test_pin, int_pullup_pin, gp_pin, wake_input_pin}),
        .q(pin_sync)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        clr_a = rd_strobe && hit(rd_addr, `WSSB_ADDR_WK_A);
        clr_b = rd_strobe && hit(rd_addr, `WSSB_ADDR_WK_B);
        clr_ovl = rd_strobe && hit(rd_addr, `WSSB_ADDR_OVL);
        clr_opl = rd_strobe && hit(rd_addr, `WSSB_ADDR_OPL);

        ev_a = '0;
        ev_a[`WSSB_BIT_LIN] = lin_bus_wake;
        ev_a[`WSSB_BIT_CAN] = can_bus_wake;
        ev_a[`WSSB_BIT_TIMER] = timer_wake;
        ev_a[`WSSB_BIT_WK1 +: 3] = wake_input_wake;
        ev_b = '0;
        ev_b[`WSSB_BIT_GP1 +: 2] = gp_pin_wake;
        if (failsafe_wake_exit) begin
            ev_a = ev_a | src_bits(failsafe_wake_src, 1'b0);
            ev_b = ev_b | src_bits(failsafe_wake_src, 1'b1);
        end

        // Set wins over the read clear so an event during the access is kept
        // Only reset, a read or soft_reset clears; soft_reset clears all four flag registers below
        next_s.wk_a = ((s.wk_a & ~{8{clr_a}}) | ev_a) & `WSSB_MASK_WK_A;
        next_s.wk_b = ((s.wk_b & ~{8{clr_b}}) | ev_b) & `WSSB_MASK_WK_B;
        next_s.ovl = ((s.ovl & ~{8{clr_ovl}}) | {4'h0, switch_overload_event}) & `WSSB_MASK_HS;
        next_s.opl = ((s.opl & ~{8{clr_opl}}) | {4'h0, switch_open_load_event}) & `WSSB_MASK_HS;

        if (soft_reset) begin
            next_s.wk_a = `WSSB_RESET_FLAGS;
            next_s.wk_b = `WSSB_RESET_FLAGS;
            next_s.ovl = `WSSB_RESET_FLAGS;
            next_s.opl = `WSSB_RESET_FLAGS;
        end

        // Straps are taken once, after the synchronisers have filled
        case (s.st)
            WSSB_ST_SETTLE: begin
                next_s.settle = s.settle + 3'h1;
                if (s.settle == `WSSB_STRAP_SETTLE) begin
                    next_s.dev_mode_strap = pin_sync[6];
                    next_s.int_pullup_strap = pin_sync[5];
                    next_s.st = WSSB_ST_LIVE;
                end
            end
            WSSB_ST_LIVE: next_s.settle = s.settle;
            default: next_s.st = WSSB_ST_SETTLE;
        endcase

        // GP pins follow live level only while gp_selected or mode_normal_stop with gp_cfg_wake_or_switch, else hold; no cyclic path exists for them
        gp_refresh = gp_selected | ({2{mode_normal_stop}} & gp_cfg_wake_or_switch);
        for (int i = 0; i < 2; i++) begin
            if (gp_refresh[i]) begin
                next_s.gp_lvl[i] = pin_sync[3 + i];
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (!wake_cyclic[i] || wake_sample[i]) begin
                next_s.wk_lvl[i] = pin_sync[i];
            end
        end

        // Read data is the value before this access clears it
        next_s.rd_valid = rd_strobe;
        if (rd_strobe) begin
            if (clr_a) begin
                next_s.rd_data = s.wk_a & `WSSB_MASK_WK_A;
            end else if (clr_b) begin
                next_s.rd_data = s.wk_b & `WSSB_MASK_WK_B;
            end else if (hit(rd_addr, `WSSB_ADDR_LVL)) begin
                next_s.rd_data = level_byte(s);
            end else if (clr_ovl) begin
                next_s.rd_data = s.ovl & `WSSB_MASK_HS;
            end else if (clr_opl) begin
                next_s.rd_data = s.opl & `WSSB_MASK_HS;
            end else begin
                next_s.rd_data = '0;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_lin_flag_set: assert property (lin_bus_wake && !soft_reset |=> s.wk_a[`WSSB_BIT_LIN])
        else $error("LIN wake flag not set");
    a_gp_flag_set: assert property (gp_pin_wake[1] && !soft_reset |=> s.wk_b[`WSSB_BIT_GP1 + 1])
        else $error("GP2 wake flag not set");
    a_reserved_zero: assert property (rd_valid && $past(hit(rd_addr, `WSSB_ADDR_OVL)) |-> rd_data[7:4] == 4'h0)
        else $error("Reserved bits not zero");
    a_failsafe_src_flag: assert property (failsafe_wake_exit && failsafe_wake_src == WSSB_SRC_CAN && !soft_reset
        |=> s.wk_a[`WSSB_BIT_CAN])
        else $error("Fail-safe wake source flag missing");
    a_dev_strap_hold: assert property (s.st == WSSB_ST_LIVE |=> $stable(s.dev_mode_strap))
        else $error("Mode strap changed after capture");
    a_pullup_strap_hold: assert property (s.st == WSSB_ST_LIVE |=> $stable(s.int_pullup_strap))
        else $error("Pull-up strap changed after capture");
    a_wake_level_live: assert property (!wake_cyclic[1] |=> s.wk_lvl[1] == $past(pin_sync[1]))
        else $error("Wake input level not live");
    a_gp_level_mode: assert property (mode_normal_stop && gp_cfg_wake_or_switch[1]
        |=> s.gp_lvl[1] == $past(pin_sync[4]))
        else $error("GP level not refreshed");
    a_cyclic_hold: assert property (wake_cyclic[0] && !wake_sample[0] |=> $stable(s.wk_lvl[0]))
        else $error("Cyclic level moved without sample");
    a_gp_no_cyclic: assert property (!gp_selected[0] && !(mode_normal_stop && gp_cfg_wake_or_switch[0])
        |=> $stable(s.gp_lvl[0]))
        else $error("GP level moved while not refreshed");
    a_gp_selected_level: assert property (gp_selected[0] |=> s.gp_lvl[0] == $past(pin_sync[3]))
        else $error("Selected GP level not shown");
    a_overload_set: assert property (switch_overload_event[3] && !soft_reset |=> s.ovl[3] ##1 s.ovl[3] || $past(clr_ovl))
        else $error("Overload flag not latched");
    a_open_load_set: assert property (switch_open_load_event[0] && !soft_reset |=> s.opl[0])
        else $error("Open-load flag not latched");
    a_soft_reset_clear: assert property (soft_reset |=> s.wk_a == 8'h00 && s.wk_b == 8'h00
        && s.ovl == 8'h00 && s.opl == 8'h00)
        else $error("Soft reset left flags set");
    a_flag_kept: assert property (s.ovl[2] && !clr_ovl && !soft_reset |=> s.ovl[2])
        else $error("Flag cleared by itself");
    a_read_old_value: assert property (clr_opl |=> rd_valid && rd_data == ($past(s.opl) & `WSSB_MASK_HS))
        else $error("Read did not return old value");
    a_set_wins: assert property (clr_a && timer_wake && !soft_reset |=> s.wk_a[`WSSB_BIT_TIMER])
        else $error("Event lost during read clear");
    // Further per-source and per-register checks
    a_can_flag_set: assert property (can_bus_wake && !soft_reset |=> s.wk_a[`WSSB_BIT_CAN])
        else $error("CAN wake flag not set");
    a_timer_flag_set: assert property (timer_wake && !soft_reset |=> s.wk_a[`WSSB_BIT_TIMER])
        else $error("Timer wake flag not set");
    a_wake_in_flag: assert property (wake_input_wake[2] && !soft_reset |=> s.wk_a[`WSSB_BIT_WK1 + 2])
        else $error("Wake input flag not set");
    a_gp1_flag_set: assert property (gp_pin_wake[0] && !soft_reset |=> s.wk_b[`WSSB_BIT_GP1])
        else $error("GP1 wake flag not set");
    a_wake_reserved: assert property (rd_valid && $past(rd_strobe && hit(rd_addr, `WSSB_ADDR_WK_A))
        |-> !rd_data[7] && !rd_data[3])
        else $error("Wake register reserved bits not zero");
    a_level_reserved: assert property (rd_valid && $past(rd_strobe && hit(rd_addr, `WSSB_ADDR_LVL))
        |-> !rd_data[3])
        else $error("Level register reserved bit not zero");
    a_failsafe_gp_flag: assert property (failsafe_wake_exit && failsafe_wake_src == WSSB_SRC_GP2 && !soft_reset
        |=> s.wk_b[`WSSB_BIT_GP1 + 1])
        else $error("Fail-safe GP wake flag missing");
    a_dev_strap_read: assert property (rd_strobe && hit(rd_addr, `WSSB_ADDR_LVL)
        |=> rd_data[`WSSB_BIT_DEV] == $past(s.dev_mode_strap))
        else $error("Mode strap not shown");
    a_pullup_strap_read: assert property (rd_strobe && hit(rd_addr, `WSSB_ADDR_LVL)
        |=> rd_data[`WSSB_BIT_PULLUP] == $past(s.int_pullup_strap))
        else $error("Pull-up strap not shown");
    a_cyclic_sampled: assert property (wake_sample[2] |=> s.wk_lvl[2] == $past(pin_sync[2]))
        else $error("Cyclic sample not taken");
    a_wake_a_kept: assert property (s.wk_a[`WSSB_BIT_LIN] && !clr_a && !soft_reset |=> s.wk_a[`WSSB_BIT_LIN])
        else $error("Wake flag cleared by itself");
    a_open_load_kept: assert property (s.opl[1] && !clr_opl && !soft_reset |=> s.opl[1])
        else $error("Open-load flag cleared by itself");
    a_wake_b_clear: assert property (clr_b && gp_pin_wake == 2'h0 && !failsafe_wake_exit && !soft_reset
        |=> s.wk_b == 8'h00)
        else $error("Wake flags not cleared by read");
    a_read_answer: assert property (rd_strobe |=> rd_valid)
        else $error("Read not answered");

    c_read_clear: cover property (clr_a && s.wk_a != 8'h00 ##1 s.wk_a == 8'h00);
    c_failsafe_wake: cover property (failsafe_wake_exit && failsafe_wake_src == WSSB_SRC_GP1);
    c_cyclic_sample: cover property (wake_cyclic[2] && wake_sample[2]);
    c_set_during_read: cover property (clr_ovl && switch_overload_event != 4'h0);
    c_strap_taken: cover property (s.st == WSSB_ST_SETTLE ##1 s.st == WSSB_ST_LIVE);
endmodule // wssb_bank

// ==== bench/wssb_host.sv ====
// Host model: the serial master seen through the bank's internal read port.
// Assumes calls are made from the bench at any time; each access aligns to ref_clk itself.
`timescale 1ns/100ps
module wssb_host (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic rd_strobe,
    output logic [6:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        rd_strobe = 1'b0;
        rd_addr = 7'h7f;
    end

    // One read per call; the old value is taken once, which is what clears a flag
    // Overload flags are only trusted with a healthy supply; the model has none, so it trusts them
    task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
        @(posedge ref_clk);
        #1;
        rd_strobe = 1'b1;
        rd_addr = a;
        @(posedge ref_clk);
        #1;
        ok = rd_valid;
        d = rd_data;
        rd_strobe = 1'b0;
        // A released address must not keep showing the last value
        rd_addr = ~a;
    endtask
endmodule // wssb_host

// ==== bench/wssb_bank_tb.sv ====
// Self-checking bench for the wake and switch status bank.
// Assumes the register header and package are compiled first.
`timescale 1ns/100ps
`include "wssb_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module wssb_bank_tb;
    import wssb_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk, resetn, soft_reset, rd_strobe, rd_valid, fs_exit, test_pin, pull_pin, mode_ns;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic [15:0] wk;
    wssb_src_t fs_src;
    logic [3:0] ov, ol;
    logic [1:0] gp_pin, gp_sel, gp_cfg;
    logic [2:0] wk_pin, wk_cyc, wk_smp;
    int err_count = 0;
    int n_tests = 0;
    int bp[8] = '{0, 1, 2, 4, 5, 6, 12, 13};
    logic [15:0] e;

    wssb_host host (.ref_clk(ref_clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid));
    // wk holds register A in its low byte and register B in its high byte
    wssb_bank dut (.ref_clk(ref_clk), .resetn(resetn), .soft_reset(soft_reset), .rd_strobe(rd_strobe),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .lin_bus_wake(wk[6]),
        .can_bus_wake(wk[5]), .timer_wake(wk[4]), .wake_input_wake(wk[2:0]), .gp_pin_wake(wk[13:12]),
        .failsafe_wake_exit(fs_exit), .failsafe_wake_src(fs_src), .switch_overload_event(ov),
        .switch_open_load_event(ol), .fail_output_test_pin(test_pin), .int_pullup_pin(pull_pin),
        .gp_pin(gp_pin), .wake_input_pin(wk_pin), .mode_normal_stop(mode_ns),
        .gp_cfg_wake_or_switch(gp_cfg), .gp_selected(gp_sel), .wake_cyclic(wk_cyc), .wake_sample(wk_smp));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic rd(input logic [6:0] a, input logic [7:0] x);
        logic [7:0] d;
        logic ok;
        host.read_reg(a, d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, x)
    endtask

    task automatic pulse(input logic [15:0] w, input logic [3:0] o, input logic [3:0] l, input logic f,
        input logic s);
        @(posedge ref_clk);
        #1;
        wk = w; ov = o; ol = l; fs_exit = f; soft_reset = s; wk_smp = {3{f & s}};
        @(posedge ref_clk);
        #1;
        wk = '0; ov = '0; ol = '0; fs_exit = 1'b0; soft_reset = 1'b0; wk_smp = '0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        finish_test();
    end

    initial begin
        resetn = 1'b0; soft_reset = 1'b0; wk = '0; fs_exit = 1'b0; fs_src = WSSB_SRC_WK1; ov = '0; ol = '0;
        test_pin = 1'b1; pull_pin = 1'b0; gp_pin = 2'b10; wk_pin = 3'b101; mode_ns = 1'b0;
        gp_cfg = 2'b00; gp_sel = 2'b11; wk_cyc = '0; wk_smp = '0;
        wait_cyc(5);
        resetn = 1'b1;
        wait_cyc(12);
        rd(7'h46, 8'h00);
        rd(7'h47, 8'h00);
        rd(7'h54, 8'h00);
        rd(7'h55, 8'h00);
        rd(7'h50, 8'h00);
        rd(7'h48, 8'ha5);
        // Every wake source, first as its own event, then as the cause of a fail-safe exit
        for (int i = 0; i < 16; i++) begin
            e = 16'h0001 << bp[i % 8];
            fs_src = wssb_src_t'(i % 8);
            pulse((i < 8) ? e : 16'h0000, 4'h0, 4'h0, i >= 8, 1'b0);
            rd(7'h46, e[7:0]);
            rd(7'h47, e[15:8]);
            rd(7'h46, 8'h00);
            rd(7'h47, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            pulse('0, 4'h1 << i, 4'h8 >> i, 1'b0, 1'b0);
            rd(7'h54, 8'h01 << i);
            rd(7'h55, 8'h08 >> i);
            rd(7'h54, 8'h00);
        end
        // An event landing on the clearing read must survive it
        fork
            rd(7'h46, 8'h00);
            pulse(16'h0020, 4'h0, 4'h0, 1'b0, 1'b0);
        join
        rd(7'h46, 8'h20);
        pulse(16'hffff, 4'hf, 4'hf, 1'b0, 1'b0);
        wait_cyc(100);
        rd(7'h46, 8'h77);
        rd(7'h47, 8'h30);
        // Soft reset beats an event arriving at the same edge
        pulse(16'h0000, 4'hf, 4'hf, 1'b0, 1'b1);
        rd(7'h54, 8'h00);
        rd(7'h55, 8'h00);
        gp_pin = 2'b01; wk_pin = 3'b010;
        wait_cyc(10);
        rd(7'h48, 8'h92);
        gp_sel = 2'b00; wk_cyc = 3'b111; gp_pin = 2'b10; wk_pin = 3'b101;
        wait_cyc(10);
        rd(7'h48, 8'h92);
        pulse('0, 4'h0, 4'h0, 1'b1, 1'b1);
        rd(7'h48, 8'h95);
        mode_ns = 1'b1; gp_cfg = 2'b11;
        wait_cyc(4);
        rd(7'h48, 8'ha5);
        // A second reset clears latched flags and takes the straps again
        pulse(16'h1040, 4'h2, 4'h4, 1'b0, 1'b0);
        resetn = 1'b0; test_pin = 1'b0; pull_pin = 1'b1;
        wait_cyc(5);
        resetn = 1'b1;
        wait_cyc(12);
        rd(7'h46, 8'h00);
        rd(7'h47, 8'h00);
        rd(7'h54, 8'h00);
        rd(7'h55, 8'h00);
        rd(7'h48, 8'h60);
        finish_test();
    end
endmodule // wssb_bank_tb
